/* File: src/smi_slave_front.v */
// Notes on behaviour
// - respond only when enable bits match straps
// - strap weights low, mid, high bit
// - data changes only while scl low
// - sda fall with scl high starts
// - sda rise with scl high stops
// - master makes start/stop; busy between them
// - bytes are eight bits, count unlimited
// - ninth clock carries the acknowledge
// - bits travel most significant first
// - slave only, scl is input only
// - sda open drain, low or released
// - write protect high blocks writes only
// - power-on hold at most 75 us
// - write accepts one to 32 bytes
// - sequential read runs through whole array
// - control byte 1010, enables, direction bit
// - acknowledge matched control and later bytes
// - write protect sampled at stop
`timescale 1ns/1ns
`default_nettype none
`include "smi_regs.vh"
module smi_slave_front (
  input  wire        clk_sys,
  input  wire        reset,
  input  wire        clk_en,
  input  wire        scl_pin,
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe,
  input  wire        select_strap_low,
  input  wire        select_strap_mid,
  input  wire        select_strap_high,
  input  wire        write_protect,
  output wire        bus_busy,
  output wire        dev_selected,
  output wire        write_cycle,
  output wire        por_active
);

  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_RX   = 6'h02;
  localparam [5:0] ST_ACK  = 6'h04;
  localparam [5:0] ST_TX   = 6'h08;
  localparam [5:0] ST_RACK = 6'h10;
  localparam [5:0] ST_IGN  = 6'h20;

  // longest hold rounds down; cut to the counter width on purpose
  localparam integer          POR_HOLD = `SMI_POR_US * `SMI_CLK_MHZ - 1;
  localparam [`SMI_POR_W-1:0] POR_LAST = POR_HOLD[`SMI_POR_W-1:0];

  //////////////////////////////////////////////////////////////////////////////
  wire [`SMI_SYNC_W-1:0] sync_now;
  wire [`SMI_SYNC_W-1:0] sync_prev;

  smi_sync #(
    .WIDTH     (`SMI_SYNC_W),
    .RESET_VAL (`SMI_SYNC_IDLE)
  ) u_sync (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .clk_en    (clk_en),
    .async_in  ({write_protect, select_strap_high, select_strap_mid,
                 select_strap_low, sda_in, scl_pin}),
    .sync_now  (sync_now),
    .sync_prev (sync_prev)
  );

  wire       scl_now  = sync_now[`SMI_IX_SCL];
  wire       scl_old  = sync_prev[`SMI_IX_SCL];
  wire       sda_now  = sync_now[`SMI_IX_SDA];
  wire       sda_old  = sync_prev[`SMI_IX_SDA];
  wire       wp_now   = sync_now[`SMI_IX_WP];
  wire [2:0] strap_v  = sync_now[`SMI_IX_EN_HI:`SMI_IX_EN_LO];
  wire       scl_rise = scl_now & ~scl_old;
  wire       scl_fall = ~scl_now & scl_old;
  // sda moving under a steady high scl is a bus condition, never data
  wire       start_det = scl_now & scl_old & sda_old & ~sda_now;
  wire       stop_det  = scl_now & scl_old & ~sda_old & sda_now;

  function ctrl_match;
    input [`SMI_BYTE_W-1:0] cbyte;
    input [2:0]             straps;
    begin
      ctrl_match = (cbyte[`SMI_CODE_HI:`SMI_CODE_LO] == `SMI_CTRL_CODE) &&
                   (cbyte[`SMI_EN_HI:`SMI_EN_LO] == straps);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  reg [`SMI_BYTE_W-1:0]     mem [0:`SMI_MEM_DEPTH-1];
  reg [`SMI_BYTE_W-1:0]     pbuf [0:`SMI_PAGE_SIZE-1];

  reg [5:0]                 state_reg;
  reg                       por_reg;
  reg [`SMI_POR_W-1:0]      por_cnt_reg;
  reg                       busy_reg;
  reg                       sel_reg;
  reg                       rw_reg;
  reg                       sda_out_reg;
  reg                       sda_oe_reg;
  reg [2:0]                 bit_cnt_reg;
  reg                       byte_done_reg;
  reg [1:0]                 byte_idx_reg;
  reg [`SMI_BYTE_W-1:0]     shift_reg;
  reg                       mack_reg;
  reg [`SMI_ADDR_W-1:0]     ptr_reg;
  reg [`SMI_PAGE_NUM_W-1:0] page_reg;
  reg [`SMI_PAGE_SIZE-1:0]  mask_reg;
  reg                       commit_reg;
  reg [`SMI_PAGE_W-1:0]     commit_idx_reg;

  wire [`SMI_BYTE_W-1:0]    mem_rd  = mem[ptr_reg];
  wire [`SMI_PAGE_W-1:0]    ptr_off = ptr_reg[`SMI_PAGE_W-1:0];

  //////////////////////////////////////////////////////////////////////////////
  // page commit: one buffered byte per cycle after an unprotected stop
  always @(posedge clk_sys) begin
    if (clk_en && !reset && commit_reg && mask_reg[commit_idx_reg]) begin
      mem[{page_reg, commit_idx_reg}] <= pbuf[commit_idx_reg];
    end
  end

  always @(posedge clk_sys) begin
    if (clk_en && !reset && !por_reg && state_reg == ST_RX && byte_done_reg &&
        scl_fall && sel_reg && !rw_reg && byte_idx_reg == `SMI_IDX_DATA &&
        !start_det && !stop_det) begin
      pbuf[ptr_off] <= shift_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    if (reset) begin
      state_reg      <= ST_IDLE;
      por_reg        <= 1'b1;
      por_cnt_reg    <= {`SMI_POR_W{1'b0}};
      busy_reg       <= 1'b0;
      sel_reg        <= 1'b0;
      rw_reg         <= 1'b0;
      sda_out_reg    <= 1'b0;
      sda_oe_reg     <= 1'b0;
      bit_cnt_reg    <= `SMI_BIT_ZERO;
      byte_done_reg  <= 1'b0;
      byte_idx_reg   <= `SMI_IDX_CTRL;
      shift_reg      <= {`SMI_BYTE_W{1'b0}};
      mack_reg       <= 1'b0;
      ptr_reg        <= {`SMI_ADDR_W{1'b0}};
      page_reg       <= {`SMI_PAGE_NUM_W{1'b0}};
      mask_reg       <= {`SMI_PAGE_SIZE{1'b0}};
      commit_reg     <= 1'b0;
      commit_idx_reg <= {`SMI_PAGE_W{1'b0}};
    end else if (clk_en) begin
      sda_out_reg <= 1'b0;
      if (commit_reg) begin
        commit_idx_reg <= commit_idx_reg + 1'b1;
        if (commit_idx_reg == `SMI_PAGE_LAST) begin
          commit_reg <= 1'b0;
          mask_reg   <= {`SMI_PAGE_SIZE{1'b0}};
        end
      end
      if (por_reg) begin
        // bus ignored until the power-on hold runs out
        por_cnt_reg <= por_cnt_reg + 1'b1;
        if (por_cnt_reg == POR_LAST) begin
          por_reg <= 1'b0;
        end
      end else if (start_det) begin
        busy_reg      <= 1'b1;
        state_reg     <= ST_RX;
        bit_cnt_reg   <= `SMI_BIT_ZERO;
        byte_done_reg <= 1'b0;
        byte_idx_reg  <= `SMI_IDX_CTRL;
        sel_reg       <= 1'b0;
        rw_reg        <= 1'b0;
        sda_oe_reg    <= 1'b0;
        if (!commit_reg) begin
          mask_reg <= {`SMI_PAGE_SIZE{1'b0}};
        end
      end else if (stop_det) begin
        busy_reg      <= 1'b0;
        state_reg     <= ST_IDLE;
        bit_cnt_reg   <= `SMI_BIT_ZERO;
        byte_done_reg <= 1'b0;
        sel_reg       <= 1'b0;
        sda_oe_reg    <= 1'b0;
        if (!commit_reg && mask_reg != {`SMI_PAGE_SIZE{1'b0}}) begin
          // decided here; later pin changes cannot touch it
          if (!wp_now) begin
            commit_reg     <= 1'b1;
            commit_idx_reg <= {`SMI_PAGE_W{1'b0}};
          end else begin
            mask_reg <= {`SMI_PAGE_SIZE{1'b0}};
          end
        end
      end else begin
        case (state_reg)
          ST_RX: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[`SMI_MSB-1:0], sda_now};
              if (bit_cnt_reg == `SMI_BIT_LAST) begin
                byte_done_reg <= 1'b1;
              end else begin
                bit_cnt_reg <= bit_cnt_reg + 1'b1;
              end
            end else if (scl_fall && byte_done_reg) begin
              byte_done_reg <= 1'b0;
              bit_cnt_reg   <= `SMI_BIT_ZERO;
              if (byte_idx_reg == `SMI_IDX_CTRL) begin
                // busy writing: stay silent so the master can poll
                if (ctrl_match(shift_reg, strap_v) && !commit_reg) begin
                  sel_reg      <= 1'b1;
                  rw_reg       <= shift_reg[`SMI_RW_BIT];
                  sda_oe_reg   <= 1'b1;
                  state_reg    <= ST_ACK;
                  byte_idx_reg <= `SMI_IDX_ADDR_HI;
                end else begin
                  state_reg <= ST_IGN;
                end
              end else begin
                sda_oe_reg <= 1'b1;
                state_reg  <= ST_ACK;
                case (byte_idx_reg)
                  `SMI_IDX_ADDR_HI: begin
                    ptr_reg[`SMI_ADDR_W-1:`SMI_BYTE_W] <=
                      shift_reg[`SMI_HI_BITS-1:0];
                    byte_idx_reg <= `SMI_IDX_ADDR_LO;
                  end
                  `SMI_IDX_ADDR_LO: begin
                    ptr_reg[`SMI_BYTE_W-1:0] <= shift_reg;
                    page_reg <= {ptr_reg[`SMI_ADDR_W-1:`SMI_BYTE_W],
                                 shift_reg[`SMI_BYTE_W-1:`SMI_PAGE_W]};
                    byte_idx_reg <= `SMI_IDX_DATA;
                  end
                  default: begin
                    // bytes past the page end wrap to the page start
                    mask_reg[ptr_off] <= 1'b1;
                    ptr_reg[`SMI_PAGE_W-1:0] <= ptr_off + 1'b1;
                  end
                endcase
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              // ninth clock over: reads drive the first data bit, writes release for the next byte
              if (rw_reg) begin
                shift_reg   <= mem_rd;
                sda_oe_reg  <= ~mem_rd[`SMI_MSB];
                bit_cnt_reg <= `SMI_BIT_ZERO;
                state_reg   <= ST_TX;
              end else begin
                sda_oe_reg <= 1'b0;
                state_reg  <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              if (bit_cnt_reg == `SMI_BIT_LAST) begin
                byte_done_reg <= 1'b1;
              end else begin
                bit_cnt_reg <= bit_cnt_reg + 1'b1;
              end
            end else if (scl_fall) begin
              if (byte_done_reg) begin
                byte_done_reg <= 1'b0;
                sda_oe_reg    <= 1'b0;
                ptr_reg       <= ptr_reg + 1'b1;
                state_reg     <= ST_RACK;
              end else begin
                shift_reg  <= {shift_reg[`SMI_MSB-1:0], 1'b0};
                sda_oe_reg <= ~shift_reg[`SMI_MSB-1];
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              mack_reg <= ~sda_now;
            end else if (scl_fall) begin
              if (mack_reg) begin
                shift_reg   <= mem_rd;
                sda_oe_reg  <= ~mem_rd[`SMI_MSB];
                bit_cnt_reg <= `SMI_BIT_ZERO;
                state_reg   <= ST_TX;
              end else begin
                state_reg <= ST_IGN;
              end
            end
          end
          ST_IGN: begin
            sda_oe_reg <= 1'b0;
          end
          default: begin
            sda_oe_reg <= 1'b0;
            state_reg  <= ST_IDLE;
          end
        endcase
      end
    end
  end

  assign sda_out      = sda_out_reg;
  assign sda_oe       = sda_oe_reg;
  assign bus_busy     = busy_reg;
  assign dev_selected = sel_reg;
  assign write_cycle  = commit_reg;
  assign por_active   = por_reg;

endmodule
`default_nettype wire

/* File: src/smi_regs.vh */
`ifndef SMI_REGS_VH
`define SMI_REGS_VH

// clock and power-on timing
`define SMI_CLK_MHZ      50
`define SMI_POR_US       75
`define SMI_POR_W        12

// control byte layout
`define SMI_CTRL_CODE    4'hA
`define SMI_CODE_HI      7
`define SMI_CODE_LO      4
`define SMI_EN_HI        3
`define SMI_EN_LO        1
`define SMI_RW_BIT       0

// byte and bit framing
`define SMI_BYTE_W       8
`define SMI_BIT_LAST     3'h7
`define SMI_BIT_ZERO     3'h0
`define SMI_MSB          7

// byte position within a transfer
`define SMI_IDX_CTRL     2'h0
`define SMI_IDX_ADDR_HI  2'h1
`define SMI_IDX_ADDR_LO  2'h2
`define SMI_IDX_DATA     2'h3

// memory geometry
`define SMI_ADDR_W       12
`define SMI_MEM_DEPTH    4096
`define SMI_HI_BITS      4
`define SMI_PAGE_W       5
`define SMI_PAGE_SIZE    32
`define SMI_PAGE_LAST    5'h1F
`define SMI_PAGE_NUM_W   7

// synchroniser vector bit positions
`define SMI_SYNC_W       6
`define SMI_IX_SCL       0
`define SMI_IX_SDA       1
`define SMI_IX_EN_LO     2
`define SMI_IX_EN_HI     4
`define SMI_IX_WP        5
`define SMI_SYNC_IDLE    6'h03

`endif

/* File: src/smi_sync.v */
`timescale 1ns/1ns
`default_nettype none
module smi_sync #(
  parameter                    WIDTH     = 6,
  parameter [WIDTH-1:0]        RESET_VAL = 6'h03
) (
  input  wire                  clk_sys,
  input  wire                  reset,
  input  wire                  clk_en,
  input  wire [WIDTH-1:0]      async_in,
  output wire [WIDTH-1:0]      sync_now,
  output wire [WIDTH-1:0]      sync_prev
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] stage_reg;
  reg [WIDTH-1:0] prev_reg;

  // meta_reg feeds stage_reg only; edges come from stage and prev
  always @(posedge clk_sys) begin
    if (reset) begin
      meta_reg  <= RESET_VAL;
      stage_reg <= RESET_VAL;
      prev_reg  <= RESET_VAL;
    end else if (clk_en) begin
      meta_reg  <= async_in;
      stage_reg <= meta_reg;
      prev_reg  <= stage_reg;
    end
  end

  assign sync_now  = stage_reg;
  assign sync_prev = prev_reg;

endmodule
`default_nettype wire

/* File: test/smi_bus_master.sv */
`timescale 1ns/1ns
`default_nettype none
module smi_bus_master (
  input  wire logic clk_sys,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_oe
);
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // only this side makes start and stop
  task automatic start_cond;
    sda_oe = 1'b0;
    hold(2);
    scl = 1'b1;
    hold(4);
    sda_oe = 1'b1;
    hold(4);
    scl = 1'b0;
    hold(2);
  endtask
  task automatic stop_cond;
    sda_oe = 1'b1;
    hold(2);
    scl = 1'b1;
    hold(4);
    sda_oe = 1'b0;
    hold(4);
  endtask
  // data moves only while scl low
  // one fixed eight-cycle bit is the only scl pace used
  task automatic bit_xfer(input logic b, output logic r);
    sda_oe = ~b;
    hold(2);
    scl = 1'b1;
    hold(2);
    r = sda;
    hold(2);
    scl = 1'b0;
    hold(2);
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask
  task automatic get_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
    bit_xfer(~more, r);
  endtask
endmodule
`default_nettype wire

/* File: test/smi_front_props.sv */
`timescale 1ns/1ns
`default_nettype none
module smi_front_props (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic scl_pin,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic write_protect,
  input wire logic bus_busy,
  input wire logic dev_selected,
  input wire logic write_cycle,
  input wire logic por_active
);
  logic [11:0] por_cnt_reg;
  logic [7:0]  wc_cnt_reg;
  always_ff @(posedge clk_sys) begin
    if (reset) por_cnt_reg <= 12'h000;
    else if (clk_en && por_cnt_reg != 12'hFFF) por_cnt_reg <= por_cnt_reg + 12'h001;
  end
  // saturates so a stuck commit cannot wrap back to a legal count
  always_ff @(posedge clk_sys) begin
    if (reset || !write_cycle) wc_cnt_reg <= 8'h00;
    else if (clk_en && wc_cnt_reg != 8'hFF) wc_cnt_reg <= wc_cnt_reg + 8'h01;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence start_ev;
    $fell(sda_in) && scl_pin && $past(scl_pin) && !por_active;
  endsequence
  sequence stop_ev;
    $rose(sda_in) && scl_pin && $past(scl_pin) && !por_active;
  endsequence
  chk_start_busy: assert property (start_ev |-> ##[2:5] bus_busy)
    else $error("start not seen as busy");
  chk_stop_free: assert property (stop_ev |-> ##[2:5] !bus_busy)
    else $error("stop did not free bus");
  chk_open_drain: assert property (sda_out == 1'b0)
    else $error("sda driven high");
  chk_oe_scl_low: assert property ($rose(sda_oe) |-> !scl_pin)
    else $error("sda pulled while scl high");
  chk_por_quiet: assert property (por_active |-> !sda_oe && !bus_busy && !dev_selected)
    else $error("bus activity during power-on hold");
  chk_por_bound: assert property (por_active |-> por_cnt_reg <= 12'hEA7)
    else $error("power-on hold too long");
  chk_commit_len: assert property ($fell(write_cycle) |-> wc_cnt_reg == 8'h20)
    else $error("commit length wrong");
  chk_wp_blocks: assert property (write_protect && $past(write_protect, 6) |-> !$rose(write_cycle))
    else $error("commit under write protect");
  // polling during a commit is legal, so the bus may be busy; no select, no ack
  chk_commit_idle: assert property (write_cycle |-> !dev_selected && !sda_oe)
    else $error("acknowledge during commit");
  chk_sel_in_busy: assert property (dev_selected |-> bus_busy)
    else $error("selected outside transfer");
endmodule
bind smi_slave_front smi_front_props PROPS (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
  .scl_pin(scl_pin), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .write_protect(write_protect), .bus_busy(bus_busy), .dev_selected(dev_selected),
  .write_cycle(write_cycle), .por_active(por_active));
`default_nettype wire

/* File: test/smi_slave_front_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module smi_slave_front_bench;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic write_protect = 1'b0;
  logic [2:0] straps = 3'h5;
  wire scl, m_oe, dut_oe, sda_out, busy, sel, wcyc, por;
  // pulled-up wire, low while either side pulls
  wire sda = ~(m_oe | dut_oe);
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #10 clk_sys = ~clk_sys;
  smi_bus_master M (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_oe(m_oe));
  smi_slave_front DUT (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .scl_pin(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(dut_oe), .select_strap_low(straps[0]),
    .select_strap_mid(straps[1]), .select_strap_high(straps[2]),
    .write_protect(write_protect), .bus_busy(busy), .dev_selected(sel),
    .write_cycle(wcyc), .por_active(por));
  task automatic end_of_test;
    $display("compared %0d, mismatched %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [7:0] d, input logic exp_ack);
    logic a;
    M.put_byte(d, a);
    check({7'h00, a}, {7'h00, exp_ack});
  endtask
  task automatic set_addr(input logic [11:0] a);
    M.start_cond();
    check({7'h00, busy}, 8'h01);
    send(8'hAA, 1'b1);
    send({4'h0, a[11:8]}, 1'b1);
    send(a[7:0], 1'b1);
  endtask
  // wp is set to wp_late just after stop: the level at stop decides
  task automatic wr(input logic [11:0] a, input logic [23:0] d, input int n, input logic wp_late);
    logic exp_wc;
    exp_wc = ~write_protect;
    set_addr(a);
    for (int i = 0; i < n; i++) send(d[23-8*i -: 8], 1'b1);
    M.stop_cond();
    write_protect = wp_late;
    for (int k = 0; k < 12 && wcyc !== 1'b1; k++) @(negedge clk_sys);
    check({7'h00, wcyc}, {7'h00, exp_wc});
    check({7'h00, busy}, 8'h00);
    M.hold(40);
  endtask
  task automatic rd(input logic [11:0] a, input int n, input logic [15:0] e);
    logic [7:0] g;
    set_addr(a);
    M.start_cond();
    send(8'hAB, 1'b1);
    for (int i = 0; i < n; i++) begin
      M.get_byte(i < n - 1, g);
      check(g, e[15-8*i -: 8]);
    end
    M.stop_cond();
  endtask
  task automatic bad_ctrl(input logic [7:0] c);
    M.start_cond();
    send(c, 1'b0);
    check({7'h00, sel}, 8'h00);
    send(8'h00, 1'b0);
    M.stop_cond();
  endtask
  task automatic mid_byte;
    logic r;
    M.start_cond();
    send(8'hAA, 1'b1);
    repeat (4) M.bit_xfer(1'b1, r);
    M.start_cond();
    send(8'hAB, 1'b1);
    check({7'h00, sel}, 8'h01);
    M.stop_cond();
    check({7'h00, sel}, 8'h00);
  endtask
  initial begin
    int por_wait;
    repeat (4) @(negedge clk_sys);
    reset = 1'b0;
    // frozen cycles must not count toward the power-on hold
    clk_en = 1'b0;
    M.hold(100);
    clk_en = 1'b1;
    for (por_wait = 0; por_wait < 3760 && por !== 1'b0; por_wait++) @(negedge clk_sys);
    check({7'h00, por}, 8'h00);
    check({7'h00, (por_wait > 3700 && por_wait <= 3750)}, 8'h01);
    M.hold(4);
    wr(12'h01F, 24'h3C5AA5, 3, 1'b1);
    write_protect = 1'b0;
    wr(12'h020, 24'hD70000, 1, 1'b0);
    rd(12'h000, 2, 16'h5AA5);
    rd(12'h01F, 2, 16'h3CD7);
    write_protect = 1'b1;
    M.hold(8);
    wr(12'h01F, 24'h990000, 1, 1'b1);
    rd(12'h01F, 1, 16'h3C00);
    write_protect = 1'b0;
    bad_ctrl(8'hA8);
    bad_ctrl(8'hAE);
    bad_ctrl(8'hA2);
    bad_ctrl(8'hBA);
    mid_byte();
    M.hold(40);
    end_of_test();
  end
endmodule
`default_nettype wire
